// *** verilog/instr_pkg.sv ***
// Constants, register map and carrier types for the instruction executor.
// Assumes an AXI4-Lite master with 32-bit data and a 12-bit byte address.
package instr_pkg;
  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] CMD_OFF = 12'h000;
  localparam logic [11:0] ACC_OFF = 12'h004;
  localparam logic [11:0] STAT_OFF = 12'h008;
  localparam logic [11:0] TPH_OFF = 12'h00c;
  localparam logic [11:0] TDH_OFF = 12'h010;
  localparam logic [11:0] WDOG_OFF = 12'h014;
  localparam logic [3:0] FILE_PAGE = 4'h1;
  localparam logic [5:0] SP_PAGE = 6'h08;
  // ----------------------------------------------------------------
  // Opcodes and reset values
  // ----------------------------------------------------------------
  localparam logic [2:0] OP_WAKE = 3'h0;
  localparam logic [2:0] OP_LOAD_SP = 3'h1;
  localparam logic [2:0] OP_READ_SP = 3'h2;
  localparam logic [2:0] OP_HALT = 3'h3;
  localparam logic [2:0] OP_REG_SUB = 3'h4;
  localparam logic [2:0] OP_IMM_SUB = 3'h5;
  localparam logic [2:0] OP_TABLE = 3'h6;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  localparam logic [7:0] WDOG_RESET = 8'h00;
  localparam logic [7:0] WDOG_CLEAR = 8'h00;
  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {
    EXEC_IDLE = 1'b0,
    EXEC_TABLE = 1'b1
  } exec_state_t;
  typedef struct packed {
    logic [7:0] imm;
    logic dest;
    logic [5:0] index;
    logic [2:0] op;
  } cmd_t;
  typedef struct packed {
    logic busy;
    logic halted;
    logic timeout_flag_n;
    logic powerdown_flag_n;
    logic zero_flag;
    logic digit_carry_flag;
    logic carry_flag;
  } status_t;
  localparam status_t STATUS_RESET = 7'h18;
endpackage : instr_pkg

// *** verilog/instr_exec_subset.sv ***
// Executes a subset of an 8-bit core's instructions issued over AXI4-Lite.
// Assumes a combinational program memory answering rom_addr within one cycle.
//
// Summary of operation
// - load special page entry from accumulator, flags kept
// - read special page entry into accumulator, flags kept
// - halt clears watchdog counter and prescaler
// - halt sets timeout flag, clears powerdown flag
// - after halt, core ignores instructions until wake
// - register subtract: file minus accumulator, flags updated
// - destination bit picks accumulator or file register
// - immediate minus accumulator into accumulator, flags updated
// - two-cycle table read, low byte to accumulator
// - table read upper six bits to data high
//
// Our own choices: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
module instr_exec_subset (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [10:0] rom_addr,
  input wire logic [13:0] rom_rdata,
  output instr_pkg::status_t status
);
  import instr_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0] file_reg [64];
  logic [7:0] special_page [16];
  logic [7:0] accumulator, next_accumulator;
  logic [2:0] table_pointer_high, next_table_pointer_high;
  logic [5:0] table_data_high, next_table_data_high;
  logic [7:0] watchdog, next_watchdog;
  logic [7:0] watchdog_prescaler, next_watchdog_prescaler;
  status_t next_status;
  exec_state_t state, next_state;
  logic [10:0] next_rom_addr;
  logic aw_got, next_aw_got, w_got, next_w_got;
  logic [11:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic file_we, sp_we;
  logic [5:0] file_widx;
  logic [3:0] sp_widx;
  logic [7:0] file_wval, sp_wval;
  logic exec_fire, wr_fire;
  cmd_t cmd;
  logic [7:0] sub_a, sub_b;
  logic [10:0] sub_out;

  // Returns {carry, digit carry, zero, result}; carry means no borrow.
  function automatic logic [10:0] sub8(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] d;
    logic [4:0] n;
    d = {1'b0, a} - {1'b0, b};
    n = {1'b0, a[3:0]} - {1'b0, b[3:0]};
    sub8 = {~d[8], ~n[4], d[7:0] == 8'h00, d[7:0]};
  endfunction : sub8

  function automatic logic is_file(input logic [11:0] a);
    is_file = a[11:8] == FILE_PAGE;
  endfunction : is_file

  function automatic logic is_sp(input logic [11:0] a);
    is_sp = a[11:6] == SP_PAGE;
  endfunction : is_sp

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    cmd = w_data[17:0];
    next_accumulator = accumulator;
    next_table_pointer_high = table_pointer_high;
    next_table_data_high = table_data_high;
    next_status = status;
    next_state = state;
    next_rom_addr = rom_addr;
    file_we = 1'b0;
    sp_we = 1'b0;
    file_widx = cmd.index;
    sp_widx = cmd.index[3:0];
    file_wval = 8'h00;
    sp_wval = 8'h00;
    next_aw_got = aw_got;
    next_aw_addr = aw_addr;
    next_w_got = w_got;
    next_w_data = w_data;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    next_rvalid = s_axi_rvalid;
    next_rresp = s_axi_rresp;
    next_rdata = s_axi_rdata;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_got = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_got = 1'b1;
      next_w_data = s_axi_wdata & {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                                   {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    wr_fire = aw_got && w_got && !s_axi_bvalid;
    // A busy core drops every command, wake included; a halted core drops all but wake.
    exec_fire = wr_fire && aw_addr == CMD_OFF && state == EXEC_IDLE &&
                (!status.halted || cmd.op == OP_WAKE);
    sub_a = (cmd.op == OP_IMM_SUB) ? cmd.imm : file_reg[cmd.index];
    sub_b = accumulator;
    sub_out = sub8(sub_a, sub_b);
    if (wr_fire) begin
      next_aw_got = 1'b0;
      next_w_got = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = RESP_OKAY;
      if (aw_addr == ACC_OFF || aw_addr == TPH_OFF) begin
        if (state == EXEC_IDLE && aw_addr == ACC_OFF) next_accumulator = w_data[7:0];
        if (aw_addr == TPH_OFF) next_table_pointer_high = w_data[2:0];
      end else if (is_file(aw_addr)) begin
        file_we = state == EXEC_IDLE;
        file_widx = aw_addr[7:2];
        file_wval = w_data[7:0];
      end else if (is_sp(aw_addr)) begin
        sp_we = 1'b1;
        sp_widx = aw_addr[5:2];
        sp_wval = w_data[7:0];
      end else if (aw_addr != CMD_OFF) begin
        next_bresp = RESP_DECERR;
      end
    end
    next_watchdog_prescaler = watchdog_prescaler;
    next_watchdog = watchdog;
    if (!status.halted) begin
      next_watchdog_prescaler = watchdog_prescaler + 8'h01;
      if (watchdog_prescaler == 8'hff) begin
        next_watchdog = watchdog + 8'h01;
        if (watchdog == 8'hff) next_status.timeout_flag_n = 1'b0;
      end
    end
    if (exec_fire) begin
      case (cmd.op)
        OP_WAKE: next_status.halted = 1'b0;
        OP_LOAD_SP: begin
          sp_we = 1'b1;
          sp_widx = cmd.index[3:0];
          sp_wval = accumulator;
        end
        OP_READ_SP: next_accumulator = special_page[cmd.index[3:0]];
        OP_HALT: begin
          next_watchdog = WDOG_CLEAR;
          next_watchdog_prescaler = WDOG_CLEAR;
          next_status.timeout_flag_n = 1'b1;
          next_status.powerdown_flag_n = 1'b0;
          next_status.halted = 1'b1;
        end
        OP_REG_SUB, OP_IMM_SUB: begin
          next_status.carry_flag = sub_out[10];
          next_status.digit_carry_flag = sub_out[9];
          next_status.zero_flag = sub_out[8];
          if (cmd.op == OP_REG_SUB && cmd.dest) begin
            file_we = 1'b1;
            file_widx = cmd.index;
            file_wval = sub_out[7:0];
          end else begin
            next_accumulator = sub_out[7:0];
          end
        end
        OP_TABLE: begin
          next_rom_addr = {table_pointer_high, accumulator};
          next_state = EXEC_TABLE;
        end
        default: next_state = EXEC_IDLE;
      endcase
    end
    // Second cycle of the table read; accumulator bus writes are held off.
    case (state)
      EXEC_TABLE: begin
        next_accumulator = rom_rdata[7:0];
        next_table_data_high = rom_rdata[13:8];
        next_state = EXEC_IDLE;
      end
      default: ;
    endcase
    next_status.busy = next_state != EXEC_IDLE;
    next_awready = !next_aw_got && !next_bvalid;
    next_wready = !next_w_got && !next_bvalid;
    next_arready = 1'b0;
    if (s_axi_rvalid && s_axi_rready) next_rvalid = 1'b0;
    if (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready) begin
      next_arready = 1'b1;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp = RESP_OKAY;
      next_rdata = 32'h00000000;
      if (s_axi_araddr == CMD_OFF) next_rdata = 32'h00000000;
      else if (s_axi_araddr == ACC_OFF) next_rdata[7:0] = accumulator;
      else if (s_axi_araddr == STAT_OFF) next_rdata[6:0] = status;
      else if (s_axi_araddr == TPH_OFF) next_rdata[2:0] = table_pointer_high;
      else if (s_axi_araddr == TDH_OFF) next_rdata[5:0] = table_data_high;
      else if (s_axi_araddr == WDOG_OFF) next_rdata[15:0] = {watchdog, watchdog_prescaler};
      else if (is_file(s_axi_araddr)) next_rdata[7:0] = file_reg[s_axi_araddr[7:2]];
      else if (is_sp(s_axi_araddr)) next_rdata[7:0] = special_page[s_axi_araddr[5:2]];
      else next_rresp = RESP_DECERR;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      accumulator <= 8'h00;
      table_pointer_high <= 3'h0;
      table_data_high <= 6'h00;
      watchdog <= WDOG_RESET;
      watchdog_prescaler <= WDOG_RESET;
      status <= STATUS_RESET;
      state <= EXEC_IDLE;
      rom_addr <= 11'h000;
      aw_got <= 1'b0;
      aw_addr <= 12'h000;
      w_got <= 1'b0;
      w_data <= 32'h00000000;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= RESP_OKAY;
      s_axi_rdata <= 32'h00000000;
    end else begin
      accumulator <= next_accumulator;
      table_pointer_high <= next_table_pointer_high;
      table_data_high <= next_table_data_high;
      watchdog <= next_watchdog;
      watchdog_prescaler <= next_watchdog_prescaler;
      status <= next_status;
      state <= next_state;
      rom_addr <= next_rom_addr;
      aw_got <= next_aw_got;
      aw_addr <= next_aw_addr;
      w_got <= next_w_got;
      w_data <= next_w_data;
      s_axi_awready <= next_awready;
      s_axi_wready <= next_wready;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_arready <= next_arready;
      s_axi_rvalid <= next_rvalid;
      s_axi_rresp <= next_rresp;
      s_axi_rdata <= next_rdata;
    end
  end

  // Register arrays carry no reset; software must load them before use.
  always_ff @(posedge aclk) begin
    if (file_we) file_reg[file_widx] <= file_wval;
    if (sp_we) special_page[sp_widx] <= sp_wval;
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_load_sp_copy: assert property (exec_fire && cmd.op == OP_LOAD_SP |=>
    special_page[$past(cmd.index[3:0])] == $past(accumulator) && $stable(status[2:0]))
    else $error("load special page wrong");
  a_read_sp_copy: assert property (exec_fire && cmd.op == OP_READ_SP |=>
    accumulator == $past(special_page[cmd.index[3:0]]) && $stable(status[2:0]))
    else $error("read special page wrong");
  a_halt_wdog_clear: assert property (exec_fire && cmd.op == OP_HALT |=>
    watchdog == 8'h00 && watchdog_prescaler == 8'h00)
    else $error("watchdog not cleared on halt");
  a_halt_flag_update: assert property (exec_fire && cmd.op == OP_HALT |=>
    status.timeout_flag_n && !status.powerdown_flag_n)
    else $error("halt flags wrong");
  a_halt_no_fetch: assert property (status.halted && wr_fire && aw_addr == CMD_OFF &&
    cmd.op != OP_WAKE |=> status.halted && $stable(accumulator) && $stable(status[2:0]))
    else $error("instruction run while halted");
  a_sub_to_acc: assert property (exec_fire && cmd.op == OP_REG_SUB && !cmd.dest |=>
    accumulator == $past(file_reg[cmd.index]) - $past(accumulator))
    else $error("register subtract result wrong");
  a_sub_to_file: assert property (exec_fire && cmd.op == OP_REG_SUB && cmd.dest |=>
    file_reg[$past(cmd.index)] == $past(sub_a) - $past(sub_b) && $stable(accumulator))
    else $error("register subtract write back wrong");
  a_imm_sub_acc: assert property (exec_fire && cmd.op == OP_IMM_SUB |=>
    accumulator == $past(cmd.imm) - $past(accumulator))
    else $error("immediate subtract result wrong");
  a_table_low: assert property (exec_fire && cmd.op == OP_TABLE |=>
    status.busy && rom_addr == {$past(table_pointer_high), $past(accumulator)}
    ##1 !status.busy && accumulator == $past(rom_rdata[7:0]))
    else $error("table read low byte wrong");
  a_table_high: assert property (exec_fire && cmd.op == OP_TABLE |=>
    ##1 table_data_high == $past(rom_rdata[13:8]))
    else $error("table read high bits wrong");
  a_carry_borrow: assert property (exec_fire && cmd.op[2:1] == 2'b10 |=>
    status.carry_flag == ($past(sub_a) >= $past(sub_b)))
    else $error("carry flag wrong");
  a_zero_result: assert property (exec_fire && cmd.op[2:1] == 2'b10 |=>
    status.zero_flag == ($past(sub_a) == $past(sub_b)))
    else $error("zero flag wrong");

  c_table_read: cover property (exec_fire && cmd.op == OP_TABLE ##2 !status.busy);
  c_halt_wake: cover property (status.halted ##[1:20] exec_fire && cmd.op == OP_WAKE);
  c_sub_borrow: cover property (exec_fire && cmd.op[2:1] == 2'b10 ##1 !status.carry_flag);
  c_sub_zero: cover property (exec_fire && cmd.op == OP_REG_SUB ##1 status.zero_flag);
endmodule : instr_exec_subset

// *** test/tb.sv ***
// Self-checking bench for the instruction executor, driven over AXI4-Lite.
// Assumes the executor package and a combinational program memory modelled here.
`timescale 1ns/1ps
module tb;
  import instr_pkg::*;
  // ----------------------------------------------------------------
  // Signals and design
  // ----------------------------------------------------------------
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic bready = 1'b1, rready = 1'b1;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [10:0] rom_addr;
  logic [13:0] rom_rdata;
  status_t status;
  int mismatches = 0, checks = 0, seed = 32'h1224;
  always #2 aclk = ~aclk;
  // The program memory answers combinationally with a pattern that depends on every bit.
  function automatic logic [13:0] rom_word(input logic [10:0] a);
    return {a[2:0] ^ 3'h5, a[10:8], a[7:0] ^ 8'ha5};
  endfunction : rom_word
  assign rom_rdata = rom_word(rom_addr);
  instr_exec_subset dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .rom_addr(rom_addr), .rom_rdata(rom_rdata), .status(status));
  // ----------------------------------------------------------------
  // Reporting
  // ----------------------------------------------------------------
  task automatic summarize();
    if (mismatches == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : summarize
  task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  task automatic hang();
    mismatches++;
    $display("ERROR wait limit expected completion seen none");
    summarize();
  endtask : hang
  // ----------------------------------------------------------------
  // Bus cycles
  // ----------------------------------------------------------------
  // Ready lines on the response side stay high, so every answer is taken at once.
  task automatic axi_write(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp;
        break;
      end
    end
    if (n == 100) hang();
  endtask : axi_write
  task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    araddr <= a;
    arvalid <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        r = rresp;
        break;
      end
    end
    if (n == 100) hang();
  endtask : axi_read
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_write(a, d, r);
    check("bresp", {30'h0, r}, {30'h0, RESP_OKAY});
  endtask : wr
  task automatic rd_check(input string name, input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    axi_read(a, d, r);
    check("rresp", {30'h0, r}, {30'h0, RESP_OKAY});
    check(name, d, exp);
  endtask : rd_check
  task automatic cmd(input logic [2:0] op, input logic [5:0] idx, input logic dest,
                     input logic [7:0] imm);
    cmd_t c;
    c.op = op;
    c.index = idx;
    c.dest = dest;
    c.imm = imm;
    wr(CMD_OFF, {14'h0, c});
  endtask : cmd
  // Expected subtract outcome: {zero, digit carry, carry, result}.
  function automatic logic [10:0] sub_exp(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] res;
    res = a - b;
    return {res == 8'h00, a[3:0] >= b[3:0], a >= b, res};
  endfunction : sub_exp
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] a, b, v;
    logic [5:0] idx;
    logic [2:0] tph;
    logic [10:0] e;
    logic [13:0] w;
    logic [31:0] d;
    logic [1:0] r;
    logic dest;
    status_t st;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    check("status reset", {25'h0, status}, {25'h0, STATUS_RESET});
    rd_check("status reg", STAT_OFF, {25'h0, STATUS_RESET});
    axi_read(12'hffc, d, r);
    check("unmapped rresp", {30'h0, r}, {30'h0, RESP_DECERR});
    check("unmapped rdata", d, 32'h0);
    for (int s = 0; s < 16; s++) begin
      v = 8'($random(seed));
      wr(ACC_OFF, {24'h0, v});
      st = status;
      cmd(OP_LOAD_SP, 6'(s), 1'b0, 8'h00);
      rd_check("special page", 12'h200 + 12'(4 * s), {24'h0, v});
      check("flags after load", {25'h0, status}, {25'h0, st});
      wr(ACC_OFF, {24'h0, ~v});
      st = status;
      cmd(OP_READ_SP, 6'(s), 1'b0, 8'h00);
      rd_check("acc from page", ACC_OFF, {24'h0, v});
      check("flags after read", {25'h0, status}, {25'h0, st});
    end
    for (int i = 0; i < 40; i++) begin
      a = (i < 4) ? 8'(32'h10330605 >> (8 * i)) : 8'($random(seed));
      b = (i < 4) ? 8'(32'h01330506 >> (8 * i)) : 8'($random(seed));
      idx = (i == 0) ? 6'd0 : (i == 1) ? 6'd63 : 6'($random(seed));
      dest = i[0] ^ i[2];
      e = sub_exp(a, b);
      wr(12'h100 + {4'h0, idx, 2'b00}, {24'h0, a});
      wr(ACC_OFF, {24'h0, b});
      cmd(OP_REG_SUB, idx, dest, 8'h00);
      rd_check("reg sub acc", ACC_OFF, {24'h0, dest ? b : e[7:0]});
      rd_check("reg sub file", 12'h100 + {4'h0, idx, 2'b00},
               {24'h0, dest ? e[7:0] : a});
      check("reg sub flags", {29'h0, status[2:0]}, {29'h0, e[10:8]});
      wr(ACC_OFF, {24'h0, b});
      cmd(OP_IMM_SUB, 6'($random(seed)), dest, a);
      rd_check("imm sub acc", ACC_OFF, {24'h0, e[7:0]});
      check("imm sub flags", {29'h0, status[2:0]}, {29'h0, e[10:8]});
    end
    for (int i = 0; i < 8; i++) begin
      tph = (i == 0) ? 3'h7 : 3'($random(seed));
      v = (i == 1) ? 8'hff : 8'($random(seed));
      w = rom_word({tph, v});
      wr(TPH_OFF, {29'h0, tph});
      wr(ACC_OFF, {24'h0, v});
      cmd(OP_TABLE, 6'h00, 1'b0, 8'h00);
      for (int n = 0; n < 20 && status.busy !== 1'b0; n++) @(posedge aclk);
      check("table busy", {31'h0, status.busy}, 32'h0);
      rd_check("table acc", ACC_OFF, {24'h0, w[7:0]});
      rd_check("table high", TDH_OFF, {26'h0, w[13:8]});
    end
    // Let the watchdog run out once, so that halt entry really has to raise the flag again.
    for (int n = 0; n < 70000 && status.timeout_flag_n !== 1'b0; n++) @(posedge aclk);
    check("timeout expired", {31'h0, status.timeout_flag_n}, 32'h0);
    repeat (300) @(posedge aclk);
    cmd(OP_HALT, 6'h00, 1'b0, 8'h00);
    check("halt timeout", {31'h0, status.timeout_flag_n}, 32'h1);
    check("halt powerdown", {31'h0, status.powerdown_flag_n}, 32'h0);
    check("halted", {31'h0, status.halted}, 32'h1);
    rd_check("watchdog clear", WDOG_OFF, {16'h0, WDOG_CLEAR, WDOG_CLEAR});
    wr(ACC_OFF, 32'h11);
    cmd(OP_IMM_SUB, 6'h00, 1'b0, 8'h50);
    rd_check("acc while halted", ACC_OFF, 32'h11);
    rd_check("watchdog frozen", WDOG_OFF, 32'h0);
    cmd(OP_WAKE, 6'h00, 1'b0, 8'h00);
    check("woken", {31'h0, status.halted}, 32'h0);
    cmd(OP_IMM_SUB, 6'h00, 1'b0, 8'h50);
    rd_check("acc after wake", ACC_OFF, 32'h3f);
    summarize();
  end
endmodule : tb
